// ==== pfs_defs.svh ====
// constants of the program flow sequencer: file addresses, flag fields, reset values, stack depth
// Contract
// - jump loads counter low nine bits from field
// - jump top three bits from segment bits
// - invoke pushes incremented counter onto stack
// - invoke: low eight from field, bit8 zero
// - eight-level hardware stack for resume addresses
// - push shifts deeper, level 8 lost
// - pop loads counter, level 8 kept
// - plain exit restores counter, accumulator untouched
// - paged exit also updates segment bits
// - paged exit segment bits from popped 11:9
// - literal exit loads literal into accumulator
// - irq exits, one adds accumulator to timer
// - irq exits restore context from shadow copies
// - skip instructions skip next when condition holds
// - skip over page/bank prefix skips two
// - several prefixes all skipped plus one more
// - page select, bit ops, flag writes set segment
// - flags layout carry..timeout, segment at 7:5
// - counter low 02h, flags 03h, pointer 04h
// - rotate through carry, nibble swap to accumulator
// - complement, and, or, xor with accumulator
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
`define PFS_ADDR_PCL 8'h02
`define PFS_ADDR_FLAGS 8'h03
`define PFS_ADDR_PTR 8'h04
`define PFS_BIT_C 0
`define PFS_BIT_DC 1
`define PFS_BIT_Z 2
`define PFS_BIT_PD 3
`define PFS_BIT_TO 4
`define PFS_SEG_LO 5
`define PFS_SEG_HI 7
`define PFS_FLAGS_RST 8'h18
`define PFS_PC_RST 12'hFFF
`define PFS_STACK_DEPTH 8
`endif

// ==== pfs_pkg.sv ====
// types of the program flow sequencer
package pfs_pkg;
    typedef enum logic [4:0] {
        PFS_OP_NOP, PFS_OP_JMP, PFS_OP_CALL, PFS_OP_RET, PFS_OP_SUB_EXIT_WITH_PAGE, PFS_OP_SUB_EXIT_LITERAL,
        PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER, PFS_OP_DEC_SKIP_ZERO, PFS_OP_INC_SKIP_ZERO, PFS_OP_SNB, PFS_OP_SB,
        PFS_OP_PAGE, PFS_OP_BANK, PFS_OP_BIT_FORCE_HIGH, PFS_OP_BIT_FORCE_LOW, PFS_OP_MOVWF,
        PFS_OP_RL, PFS_OP_RR, PFS_OP_SWAPW, PFS_OP_NOTF, PFS_OP_NOTW,
        PFS_OP_ANDW, PFS_OP_ORW, PFS_OP_XORW
    } pfs_op_e;
    typedef logic [11:0] pfs_addr_t;
endpackage : pfs_pkg

// ==== pfs_stack.sv ====
// eight-level shift-style return stack
`timescale 1ns/1ps
module pfs_stack #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic push,
    input wire logic pop,
    input wire pfs_pkg::pfs_addr_t push_val,
    output pfs_pkg::pfs_addr_t top
);
    import pfs_pkg::*;
    pfs_addr_t lvl_q [DEPTH];

    assign top = lvl_q[0];

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_lvl
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
                lvl_q[i] <= 12'h000;
            else if (push)
                lvl_q[i] <= (i == 0) ? push_val : lvl_q[(i == 0) ? 0 : i - 1];
            else if (pop && i < DEPTH - 1)
                lvl_q[i] <= lvl_q[(i < DEPTH - 1) ? i + 1 : i];
        end
    end

    property p_deep_kept;
        @(posedge clk) disable iff (!nrst)
        pop && !push |=> lvl_q[DEPTH-1] == $past(lvl_q[DEPTH-1]) && lvl_q[DEPTH-2] == lvl_q[DEPTH-1];
    endproperty
    a_deep_kept: assert property (p_deep_kept) else $error("deepest level changed on pop");

    property p_push_shift;
        @(posedge clk) disable iff (!nrst)
        push |=> lvl_q[0] == $past(push_val) && lvl_q[1] == $past(lvl_q[0]);
    endproperty
    a_push_shift: assert property (p_push_shift) else $error("push did not shift");
endmodule : pfs_stack

// ==== pfs_core.sv ====
// program flow sequencer: counter, stack, skip chain, flags and file registers
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire pfs_pkg::pfs_op_e instr_op,
    input wire logic [8:0] instr_addr,
    input wire logic [7:0] instr_lit,
    input wire logic [7:0] file_addr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] shadow_w,
    input wire logic [7:0] shadow_flags,
    input wire logic [7:0] shadow_ptr,
    input wire logic [7:0] shadow_mode,
    input wire pfs_pkg::pfs_addr_t shadow_pc,
    input wire logic [7:0] timer_val,
    output pfs_pkg::pfs_addr_t fetch_addr,
    output logic flush,
    output logic [7:0] w_out,
    output logic [7:0] flags_out,
    output logic [7:0] ptr_out,
    output logic [7:0] mode_out,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic [7:0] timer_wdata,
    output logic timer_we,
    output logic skipping
);
    import pfs_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pfs_addr_t pc_q;
    pfs_addr_t pc_d;
    pfs_addr_t tos;
    logic [7:0] w_q;
    logic [7:0] flags_q;
    logic [7:0] ptr_q;
    logic [7:0] mode_q;
    logic skip_q;
    logic flush_q;
    logic [7:0] fwd_q;
    logic fwe_q;
    logic [7:0] tw_q;
    logic twe_q;
    logic push;
    logic pop;
    logic exec;
    logic cond;
    logic [7:0] operand;
    logic [7:0] res;
    logic [2:0] seg;

    assign seg = flags_q[`PFS_SEG_HI:`PFS_SEG_LO];
    // a skipped slot executes nothing; prefixes keep the chain alive
    assign exec = instr_valid && !skip_q;
    assign push = exec && instr_op == PFS_OP_CALL;
    assign pop = exec && (instr_op == PFS_OP_RET || instr_op == PFS_OP_SUB_EXIT_WITH_PAGE
        || instr_op == PFS_OP_SUB_EXIT_LITERAL);

    pfs_stack #(.DEPTH(`PFS_STACK_DEPTH)) u_stack (
        .clk(clk),
        .nrst(nrst),
        .push(push),
        .pop(pop),
        .push_val(pc_q + 12'h001),
        .top(tos)
    );

    // operand reads see the locally held mapped registers
    always_comb
    begin
        unique case (file_addr)
            `PFS_ADDR_PCL: operand = pc_q[7:0];
            `PFS_ADDR_FLAGS: operand = flags_q;
            `PFS_ADDR_PTR: operand = ptr_q;
            default: operand = file_rdata;
        endcase
    end

    // ----------------------------------------------------------------
    // condition test and datapath
    // ----------------------------------------------------------------
    always_comb
    begin
        cond = 1'b0;
        res = operand;
        unique case (instr_op)
            PFS_OP_DEC_SKIP_ZERO:
            begin
                res = operand - 8'h01;
                cond = (res == 8'h00);
            end
            PFS_OP_INC_SKIP_ZERO:
            begin
                res = operand + 8'h01;
                cond = (res == 8'h00);
            end
            PFS_OP_SNB: cond = !operand[bit_sel];
            PFS_OP_SB: cond = operand[bit_sel];
            PFS_OP_BIT_FORCE_HIGH: res = operand | (8'h01 << bit_sel);
            PFS_OP_BIT_FORCE_LOW: res = operand & ~(8'h01 << bit_sel);
            PFS_OP_MOVWF: res = w_q;
            PFS_OP_RL: res = {operand[6:0], flags_q[`PFS_BIT_C]};
            PFS_OP_RR: res = {flags_q[`PFS_BIT_C], operand[7:1]};
            PFS_OP_SWAPW: res = {operand[3:0], operand[7:4]};
            PFS_OP_NOTF: res = ~operand;
            PFS_OP_NOTW: res = ~w_q;
            PFS_OP_ANDW: res = w_q & operand;
            PFS_OP_ORW: res = w_q | operand;
            PFS_OP_XORW: res = w_q ^ operand;
            default: res = operand;
        endcase
    end

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    always_comb
    begin
        pc_d = pc_q + 12'h001;
        if (exec)
        begin
            unique case (instr_op)
                PFS_OP_JMP: pc_d = {seg, instr_addr};
                PFS_OP_CALL: pc_d = {seg, 1'b0, instr_addr[7:0]};
                PFS_OP_RET, PFS_OP_SUB_EXIT_WITH_PAGE, PFS_OP_SUB_EXIT_LITERAL: pc_d = tos;
                PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER: pc_d = shadow_pc;
                default:
                begin
                    if (file_we_cond() && file_addr == `PFS_ADDR_PCL)
                        pc_d = {pc_q[11:8], res};
                end
            endcase
        end
    end

    function automatic logic file_we_cond();
        return instr_op inside {PFS_OP_DEC_SKIP_ZERO, PFS_OP_INC_SKIP_ZERO, PFS_OP_BIT_FORCE_HIGH, PFS_OP_BIT_FORCE_LOW,
            PFS_OP_MOVWF, PFS_OP_RL, PFS_OP_RR, PFS_OP_NOTF};
    endfunction : file_we_cond

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pc_q <= `PFS_PC_RST;
        else if (instr_valid)
            pc_q <= pc_d;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flush_q <= 1'b0;
        else
            flush_q <= exec && (instr_op inside {PFS_OP_JMP, PFS_OP_CALL, PFS_OP_RET,
                PFS_OP_SUB_EXIT_WITH_PAGE, PFS_OP_SUB_EXIT_LITERAL, PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER});
    end

    // ----------------------------------------------------------------
    // skip chain: prefixes extend it, one cycle per skipped slot
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            skip_q <= 1'b0;
        else if (instr_valid)
        begin
            if (skip_q)
                skip_q <= instr_op inside {PFS_OP_PAGE, PFS_OP_BANK};
            else
                skip_q <= cond && instr_op inside {PFS_OP_DEC_SKIP_ZERO, PFS_OP_INC_SKIP_ZERO,
                    PFS_OP_SNB, PFS_OP_SB};
        end
    end

    // ----------------------------------------------------------------
    // flags, pointer, accumulator, mode
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flags_q <= `PFS_FLAGS_RST;
        else if (exec)
        begin
            if (instr_op == PFS_OP_PAGE)
                flags_q[`PFS_SEG_HI:`PFS_SEG_LO] <= instr_addr[2:0];
            else if (instr_op == PFS_OP_SUB_EXIT_WITH_PAGE)
                flags_q[`PFS_SEG_HI:`PFS_SEG_LO] <= tos[11:9];
            else if (instr_op inside {PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER})
                flags_q <= shadow_flags;
            else if (file_we_cond() && file_addr == `PFS_ADDR_FLAGS)
                flags_q <= res;
            else if (instr_op inside {PFS_OP_RL, PFS_OP_RR})
                flags_q[`PFS_BIT_C] <= (instr_op == PFS_OP_RL) ? operand[7] : operand[0];
            else if (instr_op inside {PFS_OP_NOTF, PFS_OP_NOTW, PFS_OP_ANDW,
                PFS_OP_ORW, PFS_OP_XORW})
                flags_q[`PFS_BIT_Z] <= (res == 8'h00);
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ptr_q <= 8'h00;
        else if (exec)
        begin
            if (instr_op == PFS_OP_BANK)
                ptr_q[6:4] <= instr_addr[2:0];
            else if (instr_op inside {PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER})
                ptr_q <= shadow_ptr;
            else if (file_we_cond() && file_addr == `PFS_ADDR_PTR)
                ptr_q <= res;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            w_q <= 8'h00;
        else if (exec)
        begin
            unique case (instr_op)
                PFS_OP_SUB_EXIT_LITERAL: w_q <= instr_lit;
                PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER: w_q <= shadow_w;
                PFS_OP_SWAPW, PFS_OP_NOTW, PFS_OP_ANDW, PFS_OP_ORW, PFS_OP_XORW: w_q <= res;
                default: w_q <= w_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            mode_q <= 8'h00;
        else if (exec && instr_op inside {PFS_OP_IRQ_EXIT, PFS_OP_IRQ_EXIT_ADD_TIMER})
            mode_q <= shadow_mode;
    end

    // ----------------------------------------------------------------
    // external writes: file registers and the realtime counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fwd_q <= 8'h00;
            fwe_q <= 1'b0;
            tw_q <= 8'h00;
            twe_q <= 1'b0;
        end
        else
        begin
            fwe_q <= exec && file_we_cond();
            fwd_q <= res;
            // adds the accumulator value in force before the shadow restore
            twe_q <= exec && instr_op == PFS_OP_IRQ_EXIT_ADD_TIMER;
            tw_q <= timer_val + w_q;
        end
    end

    assign fetch_addr = pc_q;
    assign flush = flush_q;
    assign w_out = w_q;
    assign flags_out = flags_q;
    assign ptr_out = ptr_q;
    assign mode_out = mode_q;
    assign file_wdata = fwd_q;
    assign file_we = fwe_q;
    assign timer_wdata = tw_q;
    assign timer_we = twe_q;
    assign skipping = skip_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_jmp_target;
        @(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_JMP |=> pc_q == {$past(seg), $past(instr_addr)};
    endproperty
    a_jmp_target: assert property (p_jmp_target) else $error("jump target wrong");

    property p_call_target;
        @(posedge clk) disable iff (!nrst)
        push |=> pc_q[8] == 1'b0 && pc_q[11:9] == $past(seg)
            && pc_q[7:0] == $past(instr_addr[7:0]);
    endproperty
    a_call_target: assert property (p_call_target) else $error("invoke target wrong");

    property p_call_ret;
        @(posedge clk) disable iff (!nrst)
        push |=> tos == $past(pc_q) + 12'h001;
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("resume address wrong");

    property p_sub_exit_with_page_seg;
        @(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_SUB_EXIT_WITH_PAGE |=> seg == $past(tos[11:9]) && pc_q == $past(tos);
    endproperty
    a_sub_exit_with_page_seg: assert property (p_sub_exit_with_page_seg) else $error("paged exit wrong");

    property p_ret_w;
        @(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_RET |=> w_q == $past(w_q);
    endproperty
    a_ret_w: assert property (p_ret_w) else $error("plain exit touched accumulator");

    property p_sub_exit_literal_lit;
        @(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_SUB_EXIT_LITERAL |=> w_q == $past(instr_lit);
    endproperty
    a_sub_exit_literal_lit: assert property (p_sub_exit_literal_lit) else $error("literal exit wrong");

    property p_skip;
        @(posedge clk) disable iff (!nrst)
        exec && cond && instr_op inside {PFS_OP_SB, PFS_OP_SNB, PFS_OP_DEC_SKIP_ZERO, PFS_OP_INC_SKIP_ZERO}
            && instr_valid |=> skip_q;
    endproperty
    a_skip: assert property (p_skip) else $error("skip not taken");

    property p_prefix_chain;
        @(posedge clk) disable iff (!nrst)
        skip_q && instr_valid && instr_op inside {PFS_OP_PAGE, PFS_OP_BANK}
            |=> skip_q && seg == $past(seg);
    endproperty
    a_prefix_chain: assert property (p_prefix_chain) else $error("prefix chain broken");

    property p_seq;
        @(posedge clk) disable iff (!nrst)
        instr_valid && !exec |=> pc_q == $past(pc_q) + 12'h001;
    endproperty
    a_seq: assert property (p_seq) else $error("counter did not advance");

    property p_irq_exit;
        @(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_IRQ_EXIT_ADD_TIMER |=> timer_we;
    endproperty
    a_irq_exit: assert property (p_irq_exit) else $error("timer add missing");

    c_call: cover property (@(posedge clk) disable iff (!nrst) push ##[1:20] pop);
    c_prefix: cover property (@(posedge clk) disable iff (!nrst)
        skip_q && instr_valid && instr_op == PFS_OP_PAGE);
    c_irq_exit_add_timer: cover property (@(posedge clk) disable iff (!nrst)
        exec && instr_op == PFS_OP_IRQ_EXIT_ADD_TIMER);
endmodule : pfs_core

// ==== pfs_file_model.sv ====
// behavioural model of the data file registers facing the sequencer
`timescale 1ns/1ps
module pfs_file_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] file_addr,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_rdata
);
    logic [7:0] mem_q [256];
    logic [7:0] addr_q;

    // ----------------------------------------------------------------
    // read port and delayed write port
    // ----------------------------------------------------------------
    // read is combinational so the operand is ready in the slot that uses it
    assign file_rdata = mem_q[file_addr];

    // the write pulse trails the op by one edge, so the op's address is held one cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_q <= 8'h00;
            for (int i = 0; i < 256; i++)
            begin
                mem_q[i] <= 8'(i);
            end
        end
        else
        begin
            addr_q <= file_addr;
            if (file_we)
            begin
                mem_q[addr_q] <= file_wdata;
            end
        end
    end
endmodule : pfs_file_model

// ==== program_flow_sequencer_bench.sv ====
// self-checking bench of the program flow sequencer
`timescale 1ns/1ps
`include "pfs_defs.svh"
module program_flow_sequencer_bench;
    import pfs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic instr_valid = 1'b0;
    pfs_op_e instr_op = PFS_OP_NOP;
    logic [8:0] instr_addr = 9'h000;
    logic [7:0] instr_lit = 8'h00;
    logic [7:0] file_addr = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] file_rdata;
    logic [7:0] shadow_w = 8'h6E;
    logic [7:0] shadow_flags = 8'h5B;
    logic [7:0] shadow_ptr = 8'h33;
    logic [7:0] shadow_mode = 8'h0A;
    pfs_addr_t shadow_pc = 12'h7C4;
    logic [7:0] timer_val = 8'hF0;
    pfs_addr_t fetch_addr;
    logic flush, file_we, timer_we, skipping;
    logic [7:0] w_out, flags_out, ptr_out, mode_out, file_wdata, timer_wdata;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [11:0] pc_m;
    logic [11:0] stk_m [8];
    logic [2:0] seg_m;
    logic [7:0] w_m;
    logic skip_m;
    pfs_op_e sk_op [4] = '{PFS_OP_DEC_SKIP_ZERO, PFS_OP_INC_SKIP_ZERO, PFS_OP_SNB, PFS_OP_SB};
    logic [7:0] sk_fa [4] = '{8'h01, 8'hFF, 8'h10, 8'h10};
    logic [2:0] sk_bit [4] = '{3'h0, 3'h0, 3'h0, 3'h4};

    pfs_core pfs_core_inst (.clk(clk), .nrst(nrst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_addr(instr_addr), .instr_lit(instr_lit),
        .file_addr(file_addr), .bit_sel(bit_sel), .file_rdata(file_rdata),
        .shadow_w(shadow_w), .shadow_flags(shadow_flags), .shadow_ptr(shadow_ptr),
        .shadow_mode(shadow_mode), .shadow_pc(shadow_pc), .timer_val(timer_val),
        .fetch_addr(fetch_addr), .flush(flush), .w_out(w_out), .flags_out(flags_out),
        .ptr_out(ptr_out), .mode_out(mode_out), .file_wdata(file_wdata),
        .file_we(file_we), .timer_wdata(timer_wdata), .timer_we(timer_we),
        .skipping(skipping));
    pfs_file_model pfs_file_model_inst (.clk(clk), .nrst(nrst), .file_addr(file_addr),
        .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata));

    // ----------------------------------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------------------------------
    always #2.5 clk = ~clk;

    task automatic test_done();
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // the whole sequence needs about a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // access tasks and reference model
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // drives one slot; the model tracks flow state after that slot is consumed
    task automatic issue(input pfs_op_e op, input logic [8:0] a9 = 9'h000,
        input logic [7:0] lit = 8'h00, input logic [7:0] fa = 8'h00,
        input logic [2:0] bs = 3'h0, input logic take = 1'b0);
        logic [11:0] top;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_addr <= a9;
        instr_lit <= lit;
        file_addr <= fa;
        bit_sel <= bs;
        top = stk_m[0];
        if (skip_m)
        begin
            pc_m = pc_m + 12'h001;
            skip_m = (op == PFS_OP_PAGE || op == PFS_OP_BANK);
        end
        else if (op == PFS_OP_JMP)
            pc_m = {seg_m, a9};
        else if (op == PFS_OP_CALL)
        begin
            for (int i = 7; i > 0; i--)
                stk_m[i] = stk_m[i-1];
            stk_m[0] = pc_m + 12'h001;
            pc_m = {seg_m, 1'b0, a9[7:0]};
        end
        else if (op == PFS_OP_RET || op == PFS_OP_SUB_EXIT_WITH_PAGE || op == PFS_OP_SUB_EXIT_LITERAL)
        begin
            for (int i = 0; i < 7; i++)
                stk_m[i] = stk_m[i+1];
            pc_m = top;
            if (op == PFS_OP_SUB_EXIT_WITH_PAGE)
                seg_m = top[11:9];
            if (op == PFS_OP_SUB_EXIT_LITERAL)
                w_m = lit;
        end
        else
        begin
            if (op == PFS_OP_PAGE)
                seg_m = a9[2:0];
            pc_m = pc_m + 12'h001;
            skip_m = take;
        end
    endtask : issue

    task automatic idle();
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask : idle

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        pc_m = `PFS_PC_RST;
        seg_m = 3'h0;
        w_m = 8'h00;
        skip_m = 1'b0;
        for (int i = 0; i < 8; i++)
            stk_m[i] = 12'h000;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset pc", `PFS_PC_RST, fetch_addr);
        chk("reset flags", 12'(`PFS_FLAGS_RST), 12'(flags_out));
        chk("reset w", 12'h000, 12'(w_out));
        issue(PFS_OP_NOP);
        idle();
        chk("wrap pc", pc_m, fetch_addr);
        issue(PFS_OP_PAGE, 9'h005);
        issue(PFS_OP_JMP, 9'h1A5);
        idle();
        chk("jump pc", pc_m, fetch_addr);
        chk("flush", 12'h001, 12'(flush));
        chk("page seg", 12'h005, 12'(flags_out[7:5]));
        // nine nested invokes: the oldest resume address must be lost
        issue(PFS_OP_PAGE, 9'h002);
        for (int i = 0; i < 9; i++)
            issue(PFS_OP_CALL, 9'(9'h110 + i));
        idle();
        chk("invoke pc", pc_m, fetch_addr);
        issue(PFS_OP_PAGE, 9'h006);
        for (int i = 0; i < 9; i++)
        begin
            if (i == 0)
                issue(PFS_OP_SUB_EXIT_WITH_PAGE);
            else if (i == 8)
                issue(PFS_OP_SUB_EXIT_LITERAL, 9'h000, 8'h5A);
            else
                issue(PFS_OP_RET);
            idle();
            chk("pop pc", pc_m, fetch_addr);
            chk("pop w", 12'(w_m), 12'(w_out));
            if (i == 0)
                chk("paged exit seg", 12'(seg_m), 12'(flags_out[7:5]));
        end
        // each skip kind, taken, over one prefix plus the jump behind it
        for (int k = 0; k < 4; k++)
        begin
            issue(sk_op[k], 9'h000, 8'h00, sk_fa[k], sk_bit[k], 1'b1);
            issue(PFS_OP_PAGE, 9'(k + 1));
            #1;
            chk("skipping", 12'h001, 12'(skipping));
            issue(PFS_OP_JMP, 9'h0F0);
            issue(PFS_OP_NOP);
            idle();
            chk("skip pc", pc_m, fetch_addr);
            chk("skip seg", 12'(seg_m), 12'(flags_out[7:5]));
        end
        issue(PFS_OP_SNB, 9'h000, 8'h00, 8'h10, 3'h4);
        issue(PFS_OP_JMP, 9'h033);
        idle();
        chk("no skip pc", pc_m, fetch_addr);
        issue(PFS_OP_SB, 9'h000, 8'h00, 8'h10, 3'h4, 1'b1);
        issue(PFS_OP_PAGE, 9'h001);
        issue(PFS_OP_BANK, 9'h003);
        issue(PFS_OP_PAGE, 9'h007);
        issue(PFS_OP_JMP, 9'h1FF);
        issue(PFS_OP_PAGE, 9'h004);
        idle();
        chk("chain pc", pc_m, fetch_addr);
        chk("chain seg", 12'(seg_m), 12'(flags_out[7:5]));
        // file-mapped pointer and flag bits
        issue(PFS_OP_MOVWF, 9'h000, 8'h00, `PFS_ADDR_PTR);
        issue(PFS_OP_BIT_FORCE_HIGH, 9'h000, 8'h00, `PFS_ADDR_FLAGS, 3'h5);
        issue(PFS_OP_BIT_FORCE_LOW, 9'h000, 8'h00, `PFS_ADDR_FLAGS, 3'h7);
        idle();
        seg_m = 3'h1;
        chk("pointer", 12'h05A, 12'(ptr_out));
        chk("bit op seg", 12'(seg_m), 12'(flags_out[7:5]));
        issue(PFS_OP_RL, 9'h000, 8'h00, 8'h81);
        idle();
        chk("carry after rl", 12'h001, 12'(flags_out[`PFS_BIT_C]));
        chk("rl write", 12'h102, {3'h0, file_we, file_wdata});
        issue(PFS_OP_RR, 9'h000, 8'h00, 8'h40);
        idle();
        chk("rr write", 12'h1A0, {3'h0, file_we, file_wdata});
        chk("carry after rr", 12'h000, 12'(flags_out[`PFS_BIT_C]));
        issue(PFS_OP_NOTF, 9'h000, 8'h00, 8'h55);
        idle();
        chk("complement file", 12'h1AA, {3'h0, file_we, file_wdata});
        issue(PFS_OP_SWAPW, 9'h000, 8'h00, 8'h3C);
        issue(PFS_OP_NOTW);
        issue(PFS_OP_ANDW, 9'h000, 8'h00, 8'h0F);
        issue(PFS_OP_XORW, 9'h000, 8'h00, 8'h0C);
        idle();
        chk("logic chain w", 12'h000, 12'(w_out));
        chk("zero flag", 12'h001, 12'(flags_out[`PFS_BIT_Z]));
        issue(PFS_OP_ORW, 9'h000, 8'h00, 8'h21);
        idle();
        chk("or w", 12'h021, 12'(w_out));
        // interrupt exits restore context; the timer variant adds the old w
        issue(PFS_OP_IRQ_EXIT_ADD_TIMER);
        idle();
        chk("irq pc", shadow_pc, fetch_addr);
        chk("irq w", 12'(shadow_w), 12'(w_out));
        chk("irq flags", 12'(shadow_flags), 12'(flags_out));
        chk("irq ptr", 12'(shadow_ptr), 12'(ptr_out));
        chk("irq mode", 12'(shadow_mode), 12'(mode_out));
        chk("timer add", 12'h111, {3'h0, timer_we, timer_wdata});
        shadow_pc <= 12'h2D0;
        issue(PFS_OP_IRQ_EXIT);
        idle();
        chk("irq exit pc", 12'h2D0, fetch_addr);
        test_done();
    end
endmodule : program_flow_sequencer_bench
